// [src/usp_serial_port.sv]
// Serial port: four framing modes, status and clock select, two-entry receive buffer
`timescale 1ns/1ns
`default_nettype none
`include "usp_defines.svh"

module usp_serial_port
	import usp_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Special function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	// Timer overflow pulses, bit 0 is timer 1
	input  wire logic [3:0] timer_ovf,
	// Serial data pin, open-drain in mode 0
	input  wire logic       serial_data_in,
	output logic            serial_data_out,
	output logic            serial_data_oe,
	// Shift clock in mode 0, transmit line otherwise
	output logic            shift_clock_pin,
	// Interrupt request level
	output logic            serial_irq
);

	// Picks one timer overflow pulse by a two-bit select
	function automatic logic pick_ovf(input logic [3:0] ovf, input logic [1:0] sel);
		pick_ovf = ovf[sel];
	endfunction

	// Register state
	usp_mode_type     mode;
	logic             receive_allow_bit;
	logic             tx_ninth;
	logic             transmit_done_flag;
	logic             receive_done_flag;
	logic             framing_error_flag;
	logic             receive_overrun_flag;
	logic             write_collision_flag;
	logic             baud_halving_control;
	logic [1:0]       tx_sel;
	logic [1:0]       rx_sel;
	logic [8:0]       rx_hold;
	logic             rx_unread;

	// Engine state
	usp_tx_state_type tx_state;
	usp_rx_state_type rx_state;
	logic [10:0]      tx_shift;
	logic [3:0]       tx_bits;
	logic [3:0]       tx_os;
	logic [3:0]       rx_bits;
	logic [3:0]       rx_os;
	logic [9:0]       rx_shift;
	logic [3:0]       m0_cnt;
	logic [1:0]       m2_cnt;
	logic             tx_half;
	logic             rx_half;
	logic             rx_push;
	logic [8:0]       rx_word;

	// Two-entry receive buffer
	logic [8:0]       fifo_mem [2];
	logic             fifo_wp;
	logic             fifo_rp;
	logic [1:0]       fifo_cnt;

	// Decoded strobes
	logic wr_ctrl;
	logic wr_buf;
	logic wr_stat;
	logic rd_buf;
	assign wr_ctrl = sfr_wr && (sfr_addr == `USP_ADDR_CTRL);
	assign wr_buf  = sfr_wr && (sfr_addr == `USP_ADDR_BUF);
	assign wr_stat = sfr_wr && (sfr_addr == `USP_ADDR_STAT);
	assign rd_buf  = sfr_rd && (sfr_addr == `USP_ADDR_BUF);

	// Baud ticks: mode 2 from the core clock, modes 1 and 3 from timers
	logic m2_tick;
	logic tx_src;
	logic rx_src;
	logic tx_tick;
	logic rx_tick;
	assign m2_tick = baud_halving_control ? m2_cnt[0] : (m2_cnt == 2'h3);
	assign tx_src  = pick_ovf(timer_ovf, tx_sel);
	assign rx_src  = pick_ovf(timer_ovf, rx_sel);
	// Halving drops every other overflow when the control bit is 0
	assign tx_tick = (mode == USP_MODE2) ? m2_tick
		: tx_src && (baud_halving_control || tx_half);
	assign rx_tick = (mode == USP_MODE2) ? m2_tick
		: rx_src && (baud_halving_control || rx_half);

	// Frame shape per mode
	logic [3:0] tx_len;
	logic [3:0] rx_last;
	assign tx_len  = (mode == USP_MODE0) ? `USP_M0_BITS
		: (mode == USP_MODE1) ? `USP_M1_BITS : `USP_M23_BITS;
	assign rx_last = (mode == USP_MODE1) ? 4'h8 : 4'h9;

	// Bit steps
	logic m0_busy;
	logic m0_end;
	logic tx_step;
	logic tx_done_set;
	logic tx_start;
	logic fifo_ready;
	logic m0_rx_go;
	assign m0_busy     = (mode == USP_MODE0) && ((tx_state == USP_TX_RUN) || (rx_state == USP_RX_SYNC));
	assign m0_end      = m0_busy && (m0_cnt == `USP_M0_DIV - 4'h1);
	assign tx_step     = (tx_state == USP_TX_RUN) && ((mode == USP_MODE0) ? m0_end
		: (tx_tick && (tx_os == `USP_OVERSAMPLE)));
	assign tx_done_set = tx_step && (tx_bits == tx_len - 4'h1);
	assign tx_start    = wr_buf && (tx_state == USP_TX_IDLE);
	assign fifo_ready  = (fifo_cnt != 2'h2);
	// Receive only with receive allowed, done flag clear, buffer room and line free;
	// the push cycle is blocked too, as the done flag only shows one cycle later
	assign m0_rx_go    = (mode == USP_MODE0) && receive_allow_bit && !receive_done_flag
		&& fifo_ready && (tx_state == USP_TX_IDLE) && !tx_start
		&& !rx_push;

	// Prescalers for mode 2 and the timer halving stages
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			m2_cnt  <= 2'h0;
			tx_half <= 1'b0;
			rx_half <= 1'b0;
		end
		else
		begin
			m2_cnt  <= m2_cnt + 2'h1;
			tx_half <= tx_half ^ tx_src;
			rx_half <= rx_half ^ rx_src;
		end
	end

	// Mode 0 bit timer, twelve core clocks per bit
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			m0_cnt <= 4'h0;
		else if (!m0_busy || m0_end)
			m0_cnt <= 4'h0;
		else
			m0_cnt <= m0_cnt + 4'h1;
	end

	// Transmitter; a write during a frame is dropped, not queued
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_state <= USP_TX_IDLE;
			tx_shift <= 11'h7FF;
			tx_bits  <= 4'h0;
			tx_os    <= 4'h0;
		end
		else if (tx_start)
		begin
			tx_state <= USP_TX_RUN;
			tx_bits  <= 4'h0;
			tx_os    <= 4'h0;
			if (mode == USP_MODE0)
				tx_shift <= {3'h7, sfr_wdata};
			else if (mode == USP_MODE1)
				tx_shift <= {2'h3, sfr_wdata, 1'b0};
			else
				tx_shift <= {1'b1, tx_ninth, sfr_wdata, 1'b0};
		end
		else if (tx_state == USP_TX_RUN)
		begin
			if (tx_tick && mode != USP_MODE0)
				tx_os <= tx_os + 4'h1;
			if (tx_step)
			begin
				tx_shift <= {1'b1, tx_shift[10:1]};
				tx_bits  <= tx_bits + 4'h1;
				if (tx_done_set)
					tx_state <= USP_TX_IDLE;
			end
		end
	end

	// Receiver; a word that meets a full buffer is lost and flagged
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_state <= USP_RX_IDLE;
			rx_bits  <= 4'h0;
			rx_os    <= 4'h0;
			rx_shift <= 10'h000;
			rx_push  <= 1'b0;
			rx_word  <= 9'h000;
		end
		else
		begin
			rx_push <= 1'b0;
			case (rx_state)
				USP_RX_IDLE:
				begin
					rx_bits <= 4'h0;
					rx_os   <= 4'h0;
					if (m0_rx_go)
						rx_state <= USP_RX_SYNC;
					else if (mode != USP_MODE0 && receive_allow_bit && rx_tick && !serial_data_in)
						rx_state <= USP_RX_START;
				end
				USP_RX_START:
				begin
					if (rx_tick)
						rx_os <= rx_os + 4'h1;
					// Start bit must still be low at mid-bit, else it was a glitch
					if (rx_tick && rx_os == `USP_MID_SAMPLE)
					begin
						rx_os    <= 4'h0;
						rx_state <= serial_data_in ? USP_RX_IDLE : USP_RX_DATA;
					end
				end
				USP_RX_DATA:
				begin
					if (rx_tick)
						rx_os <= rx_os + 4'h1;
					if (rx_tick && rx_os == `USP_OVERSAMPLE)
					begin
						rx_shift[rx_bits] <= serial_data_in;
						rx_bits           <= rx_bits + 4'h1;
						if (rx_bits == rx_last)
						begin
							rx_state <= USP_RX_IDLE;
							rx_push  <= 1'b1;
							// Mode 1 keeps the stop bit as the ninth bit
							rx_word  <= {(mode == USP_MODE1) ? serial_data_in : rx_shift[8],
								rx_shift[7:0]};
						end
					end
				end
				USP_RX_SYNC:
				begin
					// Sample at the rising shift clock edge
					if (m0_cnt == `USP_M0_HALF)
					begin
						rx_shift[rx_bits] <= serial_data_in;
						rx_bits           <= rx_bits + 4'h1;
						if (rx_bits == `USP_M0_BITS - 4'h1)
						begin
							rx_state <= USP_RX_IDLE;
							rx_push  <= 1'b1;
							rx_word  <= {1'b0, serial_data_in, rx_shift[6:0]};
						end
					end
				end
				default:
					rx_state <= USP_RX_IDLE;
			endcase
		end
	end

	// Receive buffer and holding register; bypass when both are empty
	logic fifo_push;
	logic fifo_pop;
	logic bypass;
	assign bypass    = rx_push && (fifo_cnt == 2'h0) && !rx_unread;
	assign fifo_push = rx_push && fifo_ready && !bypass;
	assign fifo_pop  = (fifo_cnt != 2'h0) && !rx_unread;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fifo_wp   <= 1'b0;
			fifo_rp   <= 1'b0;
			fifo_cnt  <= 2'h0;
			rx_hold   <= 9'h000;
			rx_unread <= 1'b0;
		end
		else
		begin
			if (fifo_push)
			begin
				fifo_mem[fifo_wp] <= rx_word;
				fifo_wp           <= ~fifo_wp;
			end
			if (fifo_pop)
				fifo_rp <= ~fifo_rp;
			fifo_cnt <= fifo_cnt + {1'b0, fifo_push} - {1'b0, fifo_pop};
			if (bypass)
				rx_hold <= rx_word;
			else if (fifo_pop)
				rx_hold <= fifo_mem[fifo_rp];
			if (bypass || fifo_pop)
				rx_unread <= 1'b1;
			else if (rd_buf)
				rx_unread <= 1'b0;
		end
	end

	// Control register; hardware set wins over a software clear
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode               <= USP_MODE0;
			receive_allow_bit  <= 1'b0;
			tx_ninth           <= 1'b0;
			transmit_done_flag <= 1'b0;
			receive_done_flag  <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				mode              <= usp_mode_type'(sfr_wdata[`USP_CTRL_MODE_HI:`USP_CTRL_MODE_LO]);
				receive_allow_bit <= sfr_wdata[`USP_CTRL_RXALLOW];
				tx_ninth          <= sfr_wdata[`USP_CTRL_TXNINTH];
			end
			transmit_done_flag <= (wr_ctrl ? transmit_done_flag && sfr_wdata[`USP_CTRL_TXDONE]
				: transmit_done_flag) || tx_done_set;
			receive_done_flag  <= (wr_ctrl ? receive_done_flag && sfr_wdata[`USP_CTRL_RXDONE]
				: receive_done_flag) || bypass || fifo_pop
				|| (rx_push && mode == USP_MODE0);
		end
	end

	// Status and clock select register; error flags are sticky
	logic fe_set;
	assign fe_set = (rx_state == USP_RX_DATA) && rx_tick && (rx_os == `USP_OVERSAMPLE)
		&& (rx_bits == rx_last) && !serial_data_in;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			framing_error_flag   <= 1'b0;
			receive_overrun_flag <= 1'b0;
			write_collision_flag <= 1'b0;
			baud_halving_control <= 1'b0;
			tx_sel               <= 2'h0;
			rx_sel               <= 2'h0;
		end
		else
		begin
			framing_error_flag   <= (wr_stat ? framing_error_flag && sfr_wdata[`USP_STAT_FE]
				: framing_error_flag) || fe_set;
			receive_overrun_flag <= (wr_stat ? receive_overrun_flag && sfr_wdata[`USP_STAT_OV]
				: receive_overrun_flag) || (rx_push && !fifo_ready);
			write_collision_flag <= (wr_stat ? write_collision_flag && sfr_wdata[`USP_STAT_COL]
				: write_collision_flag) || (wr_buf && tx_state == USP_TX_RUN);
			if (wr_stat)
			begin
				baud_halving_control <= sfr_wdata[`USP_STAT_HALF];
				tx_sel <= sfr_wdata[`USP_STAT_TXSEL_HI:`USP_STAT_TXSEL_LO];
				rx_sel <= sfr_wdata[`USP_STAT_RXSEL_HI:`USP_STAT_RXSEL_LO];
			end
		end
	end

	// Read data, one cycle after the read strobe; unmapped reads give zero
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			sfr_rdata <= 8'h00;
		else if (sfr_addr == `USP_ADDR_CTRL)
			sfr_rdata <= {mode, 1'b0, receive_allow_bit, tx_ninth, rx_hold[8],
				transmit_done_flag, receive_done_flag};
		else if (sfr_addr == `USP_ADDR_BUF)
			sfr_rdata <= rx_hold[7:0];
		else if (sfr_addr == `USP_ADDR_STAT)
			sfr_rdata <= {framing_error_flag, receive_overrun_flag, write_collision_flag,
				baud_halving_control, tx_sel, rx_sel};
		else
			sfr_rdata <= 8'h00;
	end

	// Pins; the data pin is only ever pulled low, never driven high
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			serial_data_oe  <= 1'b0;
			shift_clock_pin <= 1'b1;
		end
		else if (mode == USP_MODE0)
		begin
			serial_data_oe  <= (tx_state == USP_TX_RUN) && !tx_shift[0];
			shift_clock_pin <= !m0_busy || (m0_cnt >= `USP_M0_HALF);
		end
		else
		begin
			serial_data_oe  <= 1'b0;
			shift_clock_pin <= (tx_state == USP_TX_RUN) ? tx_shift[0] : 1'b1;
		end
	end
	assign serial_data_out = 1'b0;

	// Interrupt enabling is done by the core's interrupt controller
	assign serial_irq = transmit_done_flag || receive_done_flag;

	// Checks
	m0_bit_time_a: assert property (@(posedge clk) disable iff (!arst_n)
		(mode == USP_MODE0 && tx_step && tx_bits < 4'h6 && !wr_ctrl) |-> ##12 tx_step)
		else $error("mode 0 bit time is not twelve clocks");
	tx_done_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
		tx_done_set |=> transmit_done_flag && tx_state == USP_TX_IDLE)
		else $error("transmit done not set at end of frame");
	m0_rx_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rx_state == USP_RX_IDLE ##1 rx_state == USP_RX_SYNC) |->
			$past(receive_allow_bit) && !$past(receive_done_flag))
		else $error("mode 0 reception started while not allowed");
	rx_done_delay_a: assert property (@(posedge clk) disable iff (!arst_n)
		bypass |=> receive_done_flag && rx_unread)
		else $error("receive done not set one cycle after last bit");
	irq_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(transmit_done_flag) || $rose(receive_done_flag) |-> serial_irq)
		else $error("interrupt request missing");
	open_drain_a: assert property (@(posedge clk) disable iff (!arst_n)
		(mode == USP_MODE0 && tx_state == USP_TX_RUN) |=>
			serial_data_oe == !$past(tx_shift[0]) && serial_data_out == 1'b0)
		else $error("data pin not driven open-drain");
	frame_error_a: assert property (@(posedge clk) disable iff (!arst_n)
		fe_set |=> framing_error_flag ##1 framing_error_flag)
		else $error("frame error flag not raised on low stop bit");
	overrun_set_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rx_push && !fifo_ready) |=> receive_overrun_flag)
		else $error("overrun flag not raised");
	collision_set_a: assert property (@(posedge clk) disable iff (!arst_n)
		(wr_buf && tx_state == USP_TX_RUN) |=> write_collision_flag
			&& (tx_bits == $past(tx_bits) || $past(tx_step)))
		else $error("collision not flagged");
	m0_rx_halt_a: assert property (@(posedge clk) disable iff (!arst_n)
		(mode == USP_MODE0 && rx_push) |=> receive_done_flag && rx_state == USP_RX_IDLE)
		else $error("mode 0 reception did not halt after a byte");
	flags_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
		(receive_overrun_flag && !wr_stat) |=> receive_overrun_flag)
		else $error("overrun flag cleared by hardware");

endmodule // usp_serial_port
`default_nettype wire

// [src/usp_defines.svh]
// Offsets, field positions, reset values and timing counts of the serial port
`ifndef USP_DEFINES_SVH
`define USP_DEFINES_SVH

// Register addresses on the special function register port
`define USP_ADDR_CTRL      8'hA0
`define USP_ADDR_BUF       8'hA1
`define USP_ADDR_STAT      8'h91

// Reset values
`define USP_CTRL_RESET     8'h00
`define USP_STAT_RESET     8'h00

// Control register fields
`define USP_CTRL_MODE_HI   7
`define USP_CTRL_MODE_LO   6
`define USP_CTRL_RXALLOW   4
`define USP_CTRL_TXNINTH   3
`define USP_CTRL_RXNINTH   2
`define USP_CTRL_TXDONE    1
`define USP_CTRL_RXDONE    0

// Status and clock select fields
`define USP_STAT_FE        7
`define USP_STAT_OV        6
`define USP_STAT_COL       5
`define USP_STAT_HALF      4
`define USP_STAT_TXSEL_HI  3
`define USP_STAT_TXSEL_LO  2
`define USP_STAT_RXSEL_HI  1
`define USP_STAT_RXSEL_LO  0

// Timing counts in core clock cycles or baud ticks, and frame lengths in bits
`define USP_M0_DIV         4'hC
`define USP_M0_HALF        4'h6
`define USP_OVERSAMPLE     4'hF
`define USP_MID_SAMPLE     4'h7
`define USP_M0_BITS        4'h8
`define USP_M1_BITS        4'hA
`define USP_M23_BITS       4'hB

`endif

// [src/usp_pkg.sv]
// Types shared by the serial port design
package usp_pkg;
	typedef enum logic [1:0] {USP_MODE0, USP_MODE1, USP_MODE2, USP_MODE3} usp_mode_type;
	typedef enum {USP_TX_IDLE, USP_TX_RUN} usp_tx_state_type;
	typedef enum {USP_RX_IDLE, USP_RX_START, USP_RX_DATA, USP_RX_SYNC} usp_rx_state_type;
endpackage

// [test/usp_peer_model.sv]
// Serial peer: mode 0 shift register slave on a pulled-up line, plus async frame sender
`timescale 1ns/1ns
`default_nettype none

module usp_peer_model (
	// Core clock, reset and device pins
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       shift_clk,
	input  wire logic       dev_pull,
	// Byte returned in mode 0, and whether the peer drives it in mode 0
	input  wire logic       m0_drive,
	input  wire logic [7:0] m0_byte,
	// Resolved data line
	output logic            line
);
	logic       frame_pull;
	logic       out_bit;
	logic [2:0] idx;
	logic [7:0] got;

	// Both sides only sink the line; the pull-up gives the high level
	assign line = !(dev_pull || frame_pull || (m0_drive && !out_bit));

	initial
	begin
		frame_pull = 1'b0;
		out_bit = 1'b1;
		idx = 3'h0;
		got = 8'h00;
	end

	// Sample on the rising shift clock, least significant bit first
	always @(posedge shift_clk)
		if (arst_n === 1'b1)
		begin
			got <= {line, got[7:1]};
			idx <= idx + 3'h1;
		end

	// Next bit changes while the clock is low, so it is settled at the rise
	always @(negedge shift_clk)
		out_bit <= m0_byte[idx];

	// Async frame, bit 0 first, each bit held per core clocks, then released
	task automatic send(input logic [10:0] bits, input int n, input int per);
		for (int i = 0; i < n; i++)
		begin
			frame_pull = !bits[i];
			repeat (per) @(negedge clk);
		end
		frame_pull = 1'b0;
	endtask
endmodule // usp_peer_model

`default_nettype wire

// [test/usp_serial_port_test.sv]
// Self-checking bench for the serial port against a pulled-up serial peer
`timescale 1ns/1ns
`default_nettype none
`include "usp_defines.svh"

module usp_serial_port_test;
	// Design and peer connections
	logic        clk;
	logic        arst_n;
	logic [7:0]  sfr_addr;
	logic        sfr_wr;
	logic        sfr_rd;
	logic [7:0]  sfr_wdata;
	logic [7:0]  sfr_rdata;
	logic [3:0]  timer_ovf;
	logic        line;
	logic        data_out;
	logic        data_oe;
	logic        sclk;
	logic        irq;
	logic        m0_drive;
	logic [7:0]  m0_byte;
	// Scoreboard and bookkeeping
	logic [7:0]  exp_q[$];
	logic [7:0]  msk_q[$];
	logic        rd_seen;
	logic [3:0]  ovf_sel;
	logic        half_tick;
	logic [31:0] seed;
	int          n_errors;
	int          compares;
	int          cyc;
	int          n_rise;
	longint      t_rise;

	usp_serial_port u_dut (
		.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.timer_ovf(timer_ovf), .serial_data_in(line), .serial_data_out(data_out),
		.serial_data_oe(data_oe), .shift_clock_pin(sclk), .serial_irq(irq)
	);

	usp_peer_model u_peer (
		.clk(clk), .arst_n(arst_n), .shift_clk(sclk), .dev_pull(data_oe),
		.m0_drive(m0_drive), .m0_byte(m0_byte), .line(line)
	);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Overflow pulses every other clock on the selected timers only
	always @(negedge clk)
	begin
		half_tick <= !half_tick;
		timer_ovf <= half_tick ? ovf_sel : 4'h0;
	end

	// Read data is registered, so it is judged one cycle after the strobe
	always @(posedge clk)
		rd_seen <= sfr_rd;
	always @(negedge clk)
		if (rd_seen === 1'b1 && exp_q.size() > 0)
			chk_reg(sfr_rdata, exp_q.pop_front(), msk_q.pop_front());

	// Shift clock spacing inside a byte; the data pin only ever sinks
	always @(posedge sclk)
		if (arst_n === 1'b1)
		begin
			if (($time - t_rise) < 800)
			begin
				chk_val(8'(($time - t_rise) / 40), 8'h0C);
				chk_val({7'h00, data_out}, 8'h00);
			end
			t_rise = $time;
			n_rise++;
		end

	// Hang guard, well above the expected run length
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			close_out();
		end
	end

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] e, input logic [7:0] m);
		compares++;
		if ((got & m) !== (e & m))
		begin
			n_errors++;
			$display("BAD %0t register read %h expected %h", $time, got, e);
		end
	endtask

	task automatic chk_val(input logic [7:0] got, input logic [7:0] e);
		compares++;
		if (got !== e)
		begin
			n_errors++;
			$display("BAD %0t line value %h expected %h", $time, got, e);
		end
	endtask

	task automatic close_out();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(negedge clk);
		sfr_rd = 1'b0;
	endtask

	task automatic wait_irq(input int lim, output int n);
		n = 0;
		while (irq !== 1'b1 && n < lim)
		begin
			@(negedge clk);
			n++;
		end
	endtask

	// One async word in, over a chosen mode, rate and receive source
	task automatic rx_case(input logic [1:0] md, input logic hf, input logic [1:0] sel,
		input int per);
		logic [7:0] d;
		logic       nb;
		int         n;
		d = rnd();
		nb = (md == 2'd1) ? 1'b1 : seed[9];
		ovf_sel = (md == 2'd2) ? 4'h0 : 4'(1 << sel);
		wr(`USP_ADDR_STAT, {3'b000, hf, ~sel, sel});
		wr(`USP_ADDR_CTRL, {md, 6'h10});
		repeat (per) @(negedge clk);
		u_peer.send({1'b1, nb, d, 1'b0}, (md == 2'd1) ? 10 : 11, per);
		wait_irq(4 * per, n);
		rd(`USP_ADDR_BUF, d, 8'hFF);
		rd(`USP_ADDR_CTRL, {5'h00, nb, 2'b01}, 8'h05);
		wr(`USP_ADDR_CTRL, {md, 6'h10});
	endtask

	initial
	begin
		logic [7:0] d;
		logic [7:0] ws[4];
		logic [9:0] fr;
		int         n;
		seed = 32'h0000004D;
		{sfr_addr, sfr_wdata, m0_byte} = 24'h000000;
		{sfr_wr, sfr_rd, m0_drive, half_tick} = 4'h0;
		ovf_sel = 4'h0;
		timer_ovf = 4'h0;
		t_rise = 0;
		arst_n = 1'b0;
		repeat (10) @(negedge clk);
		arst_n = 1'b1;
		// Reset values, writable fields, unmapped space
		rd(`USP_ADDR_CTRL, 8'h00, 8'hFF);
		rd(`USP_ADDR_STAT, 8'h00, 8'hFF);
		d = rnd();
		wr(`USP_ADDR_STAT, d);
		rd(`USP_ADDR_STAT, d & 8'h1F, 8'hFF);
		rd(8'h55, 8'h00, 8'hFF);
		wr(`USP_ADDR_STAT, 8'h00);
		// Mode 0 send timed to the done flag
		d = rnd();
		wr(`USP_ADDR_BUF, d);
		wait_irq(200, n);
		chk_val(8'((n >= 96) && (n <= 97)), 8'h01);
		chk_val(u_peer.got, d);
		repeat (40) @(negedge clk);
		rd(`USP_ADDR_CTRL, 8'h02, 8'hFB);
		wr(`USP_ADDR_CTRL, 8'h00);
		chk_val({7'h00, irq}, 8'h00);
		// Buffer written again mid-send: dropped, collision flag held
		d = rnd();
		wr(`USP_ADDR_BUF, d);
		wr(`USP_ADDR_BUF, ~d);
		rd(`USP_ADDR_STAT, 8'h20, 8'hE0);
		wait_irq(200, n);
		chk_val(u_peer.got, d);
		rd(`USP_ADDR_STAT, 8'h20, 8'hE0);
		wr(`USP_ADDR_STAT, 8'h00);
		wr(`USP_ADDR_CTRL, 8'h00);
		rd(`USP_ADDR_STAT, 8'h00, 8'hE0);
		// Mode 0 receive: held off until allowed, halts after one byte
		m0_byte = rnd();
		m0_drive = 1'b1;
		n = n_rise;
		repeat (100) @(negedge clk);
		chk_val(8'(n_rise - n), 8'h00);
		wr(`USP_ADDR_CTRL, 8'h10);
		wait_irq(200, n);
		n = n_rise;
		repeat (150) @(negedge clk);
		chk_val(8'(n_rise - n), 8'h00);
		rd(`USP_ADDR_CTRL, 8'h11, 8'hFB);
		rd(`USP_ADDR_BUF, m0_byte, 8'hFF);
		wr(`USP_ADDR_CTRL, 8'h00);
		m0_drive = 1'b0;
		// Async receive on every source, both mode 2 rates, nine-bit modes
		for (int c = 0; c < 8; c++)
			rx_case((c < 5) ? 2'd1 : (c == 5) ? 2'd3 : 2'd2, (c != 4) && (c != 7),
				(c < 4) ? 2'(c) : 2'd1, ((c != 4) && (c != 7)) ? 32 : 64);
		// Four words unread: three kept, the fourth lost
		ovf_sel = 4'h1;
		wr(`USP_ADDR_STAT, 8'h10);
		wr(`USP_ADDR_CTRL, 8'h50);
		for (int i = 0; i < 4; i++)
		begin
			ws[i] = rnd();
			u_peer.send({2'b11, ws[i], 1'b0}, 10, 32);
			repeat (32) @(negedge clk);
		end
		rd(`USP_ADDR_STAT, 8'h40, 8'hE0);
		for (int i = 0; i < 3; i++)
		begin
			rd(`USP_ADDR_BUF, ws[i], 8'hFF);
			repeat (4) @(negedge clk);
		end
		// Low stop bit in mode 2: word kept, framing flag raised
		wr(`USP_ADDR_STAT, 8'h00);
		wr(`USP_ADDR_CTRL, 8'h90);
		d = rnd();
		u_peer.send({2'b00, d, 1'b0}, 11, 64);
		wait_irq(300, n);
		rd(`USP_ADDR_STAT, 8'h80, 8'hE0);
		rd(`USP_ADDR_BUF, d, 8'hFF);
		wr(`USP_ADDR_CTRL, 8'h80);
		wr(`USP_ADDR_STAT, 8'h00);
		rd(`USP_ADDR_STAT, 8'h00, 8'hFF);
		// Mode 1 send paced by timer 3 while receive select names timer 1
		ovf_sel = 4'h4;
		wr(`USP_ADDR_STAT, 8'h18);
		wr(`USP_ADDR_CTRL, 8'h40);
		d = rnd();
		wr(`USP_ADDR_BUF, d);
		n = 0;
		while (sclk !== 1'b0 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		repeat (16) @(negedge clk);
		for (int i = 0; i < 10; i++)
		begin
			fr[i] = sclk;
			repeat (32) @(negedge clk);
		end
		chk_val(fr[8:1], d);
		chk_val({6'h00, fr[9], fr[0]}, 8'h02);
		close_out();
	end
endmodule // usp_serial_port_test

`default_nettype wire
